// file: src/tbx_pkg.sv
// package of constants for the 16-bit timer with byte access
package tbx_pkg;
  // byte address map of the 8-bit register port
  localparam logic [3:0] ADDR_CNT_LO = 4'h0;
  localparam logic [3:0] ADDR_CNT_HI = 4'h1;
  localparam logic [3:0] ADDR_CMPA_LO = 4'h2;
  localparam logic [3:0] ADDR_CMPA_HI = 4'h3;
  localparam logic [3:0] ADDR_CMPB_LO = 4'h4;
  localparam logic [3:0] ADDR_CMPB_HI = 4'h5;
  localparam logic [3:0] ADDR_CAP_LO = 4'h6;
  localparam logic [3:0] ADDR_CAP_HI = 4'h7;
  localparam logic [3:0] ADDR_CTRL_A = 4'h8;
  localparam logic [3:0] ADDR_CTRL_B = 4'h9;
  localparam logic [3:0] ADDR_FLAG = 4'hA;
  localparam logic [3:0] ADDR_MASK = 4'hB;
  // control A fields
  localparam int CA_WM0 = 0;
  localparam int CA_WM1 = 1;
  localparam int CA_FOCB = 2;
  localparam int CA_FOCA = 3;
  // control B fields
  localparam int CB_CS0 = 0;
  localparam int CB_WM2 = 3;
  localparam int CB_WM3 = 4;
  localparam int CB_CAP_EDGE = 6;
  localparam int CB_CAP_NC = 7;
  // flag and mask fields
  localparam int FL_OVF = 0;
  localparam int FL_CMPA = 1;
  localparam int FL_CMPB = 2;
  localparam int FL_CAP = 5;
  // clock select codes
  localparam logic [2:0] CS_NONE = 3'h0;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // count limits
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  // wave modes
  localparam logic [3:0] WM_NORMAL = 4'h0;
  localparam logic [3:0] WM_PC8 = 4'h1;
  localparam logic [3:0] WM_PC9 = 4'h2;
  localparam logic [3:0] WM_PC10 = 4'h3;
  localparam logic [3:0] WM_CTC_A = 4'h4;
  localparam logic [3:0] WM_F8 = 4'h5;
  localparam logic [3:0] WM_F9 = 4'h6;
  localparam logic [3:0] WM_F10 = 4'h7;
  localparam logic [3:0] WM_PFC_CAP = 4'h8;
  localparam logic [3:0] WM_PFC_A = 4'h9;
  localparam logic [3:0] WM_PC_CAP = 4'hA;
  localparam logic [3:0] WM_PC_A = 4'hB;
  localparam logic [3:0] WM_CTC_CAP = 4'hC;
  localparam logic [3:0] WM_F_CAP = 4'hE;
  localparam logic [3:0] WM_F_A = 4'hF;
  // noise canceller run length in clock cycles
  localparam int NC_LEN = 4;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] REG16_RST = 16'h0000;
  typedef logic [15:0] tbx_word_t;
endpackage : tbx_pkg

// file: src/tbx_cap_filter.sv
// capture input filter and edge detector
`timescale 1ns/10ps
module tbx_cap_filter
  import tbx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic nc_en,
  input wire logic rise_sel,
  // capture source
  input wire logic cap_in,
  // event out
  output logic cap_evt
);
  logic [NC_LEN-1:0] hist_r;
  logic filt_r;
  logic prev_r;
  wire all_hi = &hist_r;
  wire all_lo = ~|hist_r;
  wire filt_nxt = nc_en ? (all_hi ? 1'b1 : (all_lo ? 1'b0 : filt_r)) : hist_r[0];
  // spikes shorter than the run length never reach the edge detector
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hist_r <= '0;
      filt_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      hist_r <= {hist_r[NC_LEN-2:0], cap_in};
      filt_r <= filt_nxt;
      prev_r <= filt_r;
    end
  end
  // edge choice by select bit
  assign cap_evt = rise_sel ? (filt_r & ~prev_r) : (~filt_r & prev_r);
endmodule : tbx_cap_filter

// file: src/tbx_timer16.sv
// 16-bit timer with byte-wide register access through a shared high-byte holder
// Operation
// (R01) 16-bit registers reached by two byte accesses
// (R02) one holding byte; high writes only store there
// (R03) holding byte shared by all 16-bit registers
// (R04) low write loads holder and low together
// (R05) low read copies high byte into holder
// (R06) compare reads return own high byte
// (R07) host writes high first, reads low first
// (R08) host masks interrupts around two-byte sequences
// (R09) control registers are plain 8-bit access
// (R10) flags show requests; mask gates each one
// (R11) count only on timer tick; none stops
// (R12) compare values double buffered, compared continuously
// (R13) compare match sets channel flag
// (R14) capture count on selected edge event
// (R15) optional noise filter before edge detector
// (R16) zero is bottom, all ones is max
// (R17) top fixed, from compare A or capture
// (R18) compare A as top: no PWM, buffered
// (R19) old mode bits keep positions under new names
// (R20) force-compare bits in A, mode bit 3 in B
// (R21) capture written only when it is top
// (R22) count/capture high reads return holder
`timescale 1ns/10ps
module tbx_timer16
  import tbx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // cpu byte port
  input wire logic [3:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  // clock sources
  input wire logic presc_tick,
  input wire logic external_count_pin,
  // capture sources
  input wire logic capture_pin,
  input wire logic acmp_out,
  input wire logic cap_src_acmp,
  // waveform outputs
  output logic compare_a_output,
  output logic compare_b_output,
  // interrupt requests
  output logic [7:0] irq_req
);
  import tbx_pkg::*;

  logic rs1_r;
  logic rst_n;
  // reset release through two flops
  // assertion stays asynchronous; only the release is retimed so all flops leave reset together
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end
  end

  logic [7:0] hold_r;
  tbx_word_t timer_count;
  tbx_word_t compare_a_value;
  tbx_word_t compare_b_value;
  tbx_word_t cmpa_act_r;
  tbx_word_t cmpb_act_r;
  tbx_word_t capture_value;
  logic [7:0] timer_ctrl_a;
  logic [7:0] timer_ctrl_b;
  logic [7:0] timer_flag_reg;
  logic [7:0] timer_mask_reg;
  logic dir_down_r;
  logic ext_s_r;
  logic ext_p_r;
  logic oca_r;
  logic ocb_r;
  logic [7:0] rdata_r;

  // access strobes
  wire wr_cnt_lo = cpu_wr && cpu_addr == ADDR_CNT_LO;
  wire wr_cmpa_lo = cpu_wr && cpu_addr == ADDR_CMPA_LO;
  wire wr_cmpb_lo = cpu_wr && cpu_addr == ADDR_CMPB_LO;
  wire wr_cap_lo = cpu_wr && cpu_addr == ADDR_CAP_LO;
  wire wr_hi = cpu_wr && (cpu_addr == ADDR_CNT_HI || cpu_addr == ADDR_CMPA_HI ||
                          cpu_addr == ADDR_CMPB_HI || cpu_addr == ADDR_CAP_HI);
  wire rd_cnt_lo = cpu_rd && cpu_addr == ADDR_CNT_LO;
  wire rd_cap_lo = cpu_rd && cpu_addr == ADDR_CAP_LO;
  wire [15:0] wr_word = {hold_r, cpu_wdata}; // [R04]

  // single-byte register strobes; the control A one is shared by the write and force paths
  wire wr_ctrl_a = cpu_wr && cpu_addr == ADDR_CTRL_A;
  wire wr_ctrl_b = cpu_wr && cpu_addr == ADDR_CTRL_B;
  wire wr_flag = cpu_wr && cpu_addr == ADDR_FLAG;
  wire wr_mask = cpu_wr && cpu_addr == ADDR_MASK;

  // mode fields, legacy names keep their bit places
  wire wave_mode_bit0 = timer_ctrl_a[CA_WM0]; // [R19]
  wire wave_mode_bit1 = timer_ctrl_a[CA_WM1]; // [R19]
  wire wave_mode_bit2 = timer_ctrl_b[CB_WM2]; // [R19]
  wire wave_mode_bit3 = timer_ctrl_b[CB_WM3]; // [R20]
  wire [3:0] wmode = {wave_mode_bit3, wave_mode_bit2, wave_mode_bit1, wave_mode_bit0};
  wire [2:0] clk_sel = timer_ctrl_b[CB_CS0+2:CB_CS0];

  // top selection by mode
  function automatic tbx_word_t top_of(input logic [3:0] m, input tbx_word_t a, input tbx_word_t c);
    case (m)
      WM_PC8, WM_F8: top_of = TOP_8BIT;
      WM_PC9, WM_F9: top_of = TOP_9BIT;
      WM_PC10, WM_F10: top_of = TOP_10BIT;
      WM_CTC_A, WM_PFC_A, WM_PC_A, WM_F_A: top_of = a;
      WM_PFC_CAP, WM_PC_CAP, WM_CTC_CAP, WM_F_CAP: top_of = c;
      default: top_of = CNT_MAX;
    endcase
  endfunction : top_of

  // one count step; wraps at both ends like the hardware counter
  function automatic tbx_word_t step(input tbx_word_t v, input logic down);
    step = down ? v - 16'h0001 : v + 16'h0001;
  endfunction : step

  wire [15:0] top_val = top_of(wmode, cmpa_act_r, capture_value); // [R17]
  wire a_is_top = wmode == WM_PFC_A || wmode == WM_PC_A || wmode == WM_F_A || wmode == WM_CTC_A;
  wire cap_is_top = wmode == WM_PFC_CAP || wmode == WM_PC_CAP || wmode == WM_CTC_CAP || wmode == WM_F_CAP;
  wire phase_mode = wmode == WM_PC8 || wmode == WM_PC9 || wmode == WM_PC10 ||
                    wmode == WM_PFC_CAP || wmode == WM_PFC_A || wmode == WM_PC_CAP || wmode == WM_PC_A;
  wire fast_mode = wmode == WM_F8 || wmode == WM_F9 || wmode == WM_F10 || wmode == WM_F_CAP || wmode == WM_F_A;
  wire pwm_mode = phase_mode || fast_mode;
  wire ctc_mode = wmode == WM_CTC_A || wmode == WM_CTC_CAP;

  // timer tick from prescaler or external pin edge; external sample is already synchronous
  wire ext_rise = ext_s_r & ~ext_p_r;
  wire ext_fall = ~ext_s_r & ext_p_r;
  wire timer_tick = clk_sel == CS_NONE ? 1'b0 :
                    clk_sel == CS_EXT_RISE ? ext_rise :
                    clk_sel == CS_EXT_FALL ? ext_fall : presc_tick; // [R11]

  wire at_bottom = timer_count == CNT_BOTTOM; // [R16]
  wire at_max = timer_count == CNT_MAX; // [R16]
  wire at_top = timer_count == top_val;
  wire at_top_or_max = at_top || (fast_mode && at_max);

  // pwm modes latch compare values at top, or top/max when fast; others follow writes at once
  // a mid-period compare write cannot glitch the waveform, at the cost of up to one period of lag
  wire buf_update = !pwm_mode || (timer_tick && (phase_mode ? at_top : at_top_or_max));

  // next count, cpu write has priority over counting
  tbx_word_t cnt_nxt;
  logic dir_nxt;
  always_comb
  begin
    cnt_nxt = timer_count;
    dir_nxt = dir_down_r;
    if (wr_cnt_lo)
      cnt_nxt = wr_word; // [R04]
    else if (timer_tick) // [R11]
    begin
      if (phase_mode)
      begin
        if (!dir_down_r && at_top)
        begin
          dir_nxt = 1'b1;
          cnt_nxt = step(timer_count, 1'b1);
        end
        else if (dir_down_r && at_bottom)
        begin
          dir_nxt = 1'b0;
          cnt_nxt = step(timer_count, 1'b0);
        end
        else
          cnt_nxt = step(timer_count, dir_down_r);
      end
      else if ((ctc_mode || fast_mode) && at_top)
        cnt_nxt = CNT_BOTTOM;
      else
        cnt_nxt = step(timer_count, 1'b0);
    end
  end

  // capture event from pin or comparator through filter
  // the filter adds three cycles, one less than its run length, to capture latency when enabled
  wire cap_evt;
  tbx_cap_filter u_filt (
    .clk(clk),
    .rst_n(rst_n),
    .nc_en(timer_ctrl_b[CB_CAP_NC]), // [R15]
    .rise_sel(timer_ctrl_b[CB_CAP_EDGE]),
    .cap_in(cap_src_acmp ? acmp_out : capture_pin), // [R14]
    .cap_evt(cap_evt)
  );
  // capture is top register in those modes, so events do not overwrite it
  wire do_capture = cap_evt && !cap_is_top;

  // match events, force bits act as a match without a flag in non-pwm modes only
  wire match_a = timer_tick && timer_count == cmpa_act_r; // [R12]
  wire match_b = timer_tick && timer_count == cmpb_act_r; // [R12]
  wire ovf_evt = timer_tick && (phase_mode ? (dir_down_r && at_bottom) :
                 ((ctc_mode || fast_mode) ? at_top : at_max));
  wire force_a = wr_ctrl_a && cpu_wdata[CA_FOCA] && !pwm_mode;
  wire force_b = wr_ctrl_a && cpu_wdata[CA_FOCB] && !pwm_mode;

  // flags: hardware set beats a write-one clear in the same cycle
  wire [7:0] flag_set = {2'b00, do_capture, 2'b00, match_b, match_a, ovf_evt}; // [R13]
  wire [7:0] flag_clr = wr_flag ? cpu_wdata : 8'h00;
  wire [7:0] flag_nxt = (timer_flag_reg & ~flag_clr) | flag_set; // [R10]

  // waveform: toggle in non-pwm, set/clear around match in pwm, where A stays low if compare A is top
  wire oca_nxt = a_is_top && pwm_mode ? 1'b0 : // [R18]
                 pwm_mode ? (match_a ? (phase_mode ? ~dir_down_r : 1'b0) :
                             (fast_mode && timer_tick && at_top_or_max ? 1'b1 : oca_r)) :
                 ((match_a || force_a) ? ~oca_r : oca_r);
  wire ocb_nxt = pwm_mode ? (match_b ? (phase_mode ? ~dir_down_r : 1'b0) :
                             (fast_mode && timer_tick && at_top_or_max ? 1'b1 : ocb_r)) :
                 ((match_b || force_b) ? ~ocb_r : ocb_r);

  // read mux; compare high reads bypass the holder, count/capture high read it
  // force strobes are not stored, so they always read back as zero
  wire [7:0] rd_mux = cpu_addr == ADDR_CNT_LO ? timer_count[7:0] :
                      cpu_addr == ADDR_CNT_HI ? hold_r : // [R22]
                      cpu_addr == ADDR_CMPA_LO ? compare_a_value[7:0] :
                      cpu_addr == ADDR_CMPA_HI ? compare_a_value[15:8] : // [R06]
                      cpu_addr == ADDR_CMPB_LO ? compare_b_value[7:0] :
                      cpu_addr == ADDR_CMPB_HI ? compare_b_value[15:8] : // [R06]
                      cpu_addr == ADDR_CAP_LO ? capture_value[7:0] :
                      cpu_addr == ADDR_CAP_HI ? hold_r : // [R22]
                      cpu_addr == ADDR_CTRL_A ? {4'h0, timer_ctrl_a[3:0] & 4'h3} : // [R09]
                      cpu_addr == ADDR_CTRL_B ? timer_ctrl_b : // [R09]
                      cpu_addr == ADDR_FLAG ? timer_flag_reg :
                      cpu_addr == ADDR_MASK ? timer_mask_reg : 8'h00;

  // holding byte: one per timer, any high write or count/capture low read replaces it
  // an interrupt handler writing any high byte or reading a count/capture low byte in between corrupts the pair
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_r <= 8'h00;
    else if (wr_hi)
      hold_r <= cpu_wdata; // [R02] [R03]
    else if (rd_cnt_lo)
      hold_r <= timer_count[15:8]; // [R05]
    else if (rd_cap_lo)
      hold_r <= capture_value[15:8]; // [R05]
  end

  // 16-bit registers load only on low-byte writes
  // a count write mid-run wins over that cycle's step; the next tick counts on from it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_count <= REG16_RST;
      dir_down_r <= 1'b0;
      compare_a_value <= REG16_RST;
      compare_b_value <= REG16_RST;
      capture_value <= REG16_RST;
    end
    else
    begin
      timer_count <= cnt_nxt;
      dir_down_r <= dir_nxt;
      if (wr_cmpa_lo)
        compare_a_value <= wr_word; // [R01] [R04]
      if (wr_cmpb_lo)
        compare_b_value <= wr_word; // [R01] [R04]
      if (wr_cap_lo && cap_is_top)
        capture_value <= wr_word; // [R04]
      else if (do_capture)
        capture_value <= timer_count; // [R14]
    end
  end

  // active compare copies, double buffered against the written values
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmpa_act_r <= REG16_RST;
      cmpb_act_r <= REG16_RST;
    end
    else if (buf_update)
    begin
      cmpa_act_r <= compare_a_value; // [R12] [R18]
      cmpb_act_r <= compare_b_value; // [R12]
    end
  end

  // control, flag and mask registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_ctrl_a <= CTRL_RST;
      timer_ctrl_b <= CTRL_RST;
      timer_flag_reg <= CTRL_RST;
      timer_mask_reg <= CTRL_RST;
    end
    else
    begin
      if (wr_ctrl_a)
        timer_ctrl_a <= {4'h0, 2'b00, cpu_wdata[CA_WM1:CA_WM0]}; // [R09] [R20]
      if (wr_ctrl_b)
        timer_ctrl_b <= cpu_wdata; // [R09]
      if (wr_mask)
        timer_mask_reg <= cpu_wdata;
      timer_flag_reg <= flag_nxt; // [R10]
    end
  end

  // pin sampling, outputs and read data registered
  // a clear mask bit still lets its flag set; only the request line is gated
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_s_r <= 1'b0;
      ext_p_r <= 1'b0;
      oca_r <= 1'b0;
      ocb_r <= 1'b0;
      rdata_r <= 8'h00;
      irq_req <= 8'h00;
    end
    else
    begin
      ext_s_r <= external_count_pin;
      ext_p_r <= ext_s_r;
      oca_r <= oca_nxt;
      ocb_r <= ocb_nxt;
      if (cpu_rd)
        rdata_r <= rd_mux;
      irq_req <= flag_nxt & timer_mask_reg; // [R10]
    end
  end

  // registered read data holds until the next read, so a slow host may fetch it late
  assign cpu_rdata = rdata_r;
  assign compare_a_output = oca_r;
  assign compare_b_output = ocb_r;
endmodule : tbx_timer16

// file: verification/tbx_timer16_asserts.sv
// assertions on the timer byte port and request lines
`timescale 1ns/10ps
module tbx_timer16_asserts
  import tbx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // cpu byte port
  input wire logic [3:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  // requests
  input wire logic [7:0] irq_req
);
  default clocking dck @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // shadows of cpu writes; valid bits drop wherever hardware may move a value
  logic [7:0] hold_r, ctla_r, ctlb_r, mask_r;
  logic [15:0] cnt_r, cmpa_r;
  logic hold_v_r, cnt_v_r, cmpa_v_r;
  wire hi_w = cpu_wr && cpu_addr[0] && !cpu_addr[3];
  wire cnt_lo_rd = cpu_rd && cpu_addr == ADDR_CNT_LO;
  wire cnt_lo_wr = cpu_wr && cpu_addr == ADDR_CNT_LO;
  wire cmpa_lo_wr = cpu_wr && cpu_addr == ADDR_CMPA_LO;
  wire wm0 = {ctlb_r[CB_WM3], ctlb_r[CB_WM2], ctla_r[1:0]} == WM_NORMAL;
  wire stop = ctlb_r[2:0] == CS_NONE;
  // a running count is unknown here, so its shadow is trusted only while stopped
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      hold_r <= 8'h00;
      ctla_r <= CTRL_RST;
      ctlb_r <= CTRL_RST;
      mask_r <= 8'h00;
      cnt_r <= REG16_RST;
      cmpa_r <= REG16_RST;
      hold_v_r <= 1'b0;
      cnt_v_r <= 1'b1;
      cmpa_v_r <= 1'b1;
    end
    else
    begin
      hold_r <= hi_w ? cpu_wdata : cnt_lo_rd ? cnt_r[15:8] : hold_r;
      hold_v_r <= hi_w | (cnt_lo_rd ? cnt_v_r : hold_v_r & !(cpu_rd && cpu_addr == ADDR_CAP_LO));
      cnt_r <= cnt_lo_wr ? {hold_r, cpu_wdata} : cnt_r;
      cnt_v_r <= stop & (cnt_lo_wr ? hold_v_r : cnt_v_r);
      cmpa_r <= cmpa_lo_wr ? {hold_r, cpu_wdata} : cmpa_r;
      cmpa_v_r <= wm0 & (cmpa_lo_wr ? hold_v_r : cmpa_v_r);
      ctla_r <= cpu_wr && cpu_addr == ADDR_CTRL_A ? cpu_wdata : ctla_r;
      ctlb_r <= cpu_wr && cpu_addr == ADDR_CTRL_B ? cpu_wdata : ctlb_r;
      mask_r <= cpu_wr && cpu_addr == ADDR_MASK ? cpu_wdata : mask_r;
    end
  a_unmapped_zero:
    assert property (cpu_rd && cpu_addr > ADDR_MASK |=> cpu_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds:
    assert property (!cpu_rd |=> $stable(cpu_rdata)) else $error("read data moved without a read");
  a_holder_read:
    assert property (cpu_rd && (cpu_addr == ADDR_CNT_HI || cpu_addr == ADDR_CAP_HI) && hold_v_r
      |=> cpu_rdata == hold_r) else $error("high read not from holder");
  a_count_low:
    assert property (cnt_lo_rd && cnt_v_r |=> cpu_rdata == cnt_r[7:0]) else $error("count low byte wrong");
  a_count_pair:
    assert property ((cnt_lo_rd && cnt_v_r) ##2 (cpu_rd && cpu_addr == ADDR_CNT_HI)
      |=> cpu_rdata == cnt_r[15:8]) else $error("count high byte not latched");
  a_cmp_live:
    assert property (cpu_rd && cpu_addr == ADDR_CMPA_HI && cmpa_v_r |=> cpu_rdata == cmpa_r[15:8])
      else $error("compare high read wrong");
  a_ctrl_b_back:
    assert property (cpu_rd && cpu_addr == ADDR_CTRL_B |=> (cpu_rdata & 8'hDF) == (ctlb_r & 8'hDF))
      else $error("control b readback wrong");
  a_ctrl_a_strobe:
    assert property (cpu_rd && cpu_addr == ADDR_CTRL_A |=> cpu_rdata[3:0] == {2'b00, ctla_r[1:0]})
      else $error("control a readback wrong");
  a_mask_gates:
    assert property ((irq_req & ~(mask_r | $past(mask_r) | $past(mask_r, 2))) == 8'h00)
      else $error("request passed a cleared mask bit");
  // main scenarios
  c_word_read: cover property (cnt_lo_rd ##2 (cpu_rd && cpu_addr == ADDR_CNT_HI));
  c_cmp_irq: cover property (irq_req[FL_CMPA]);
  c_cap_read: cover property (cpu_rd && cpu_addr == ADDR_CAP_LO);
endmodule : tbx_timer16_asserts

bind tbx_timer16 tbx_timer16_asserts u_tbx_timer16_asserts (.clk(clk), .arst_n(arst_n), .cpu_addr(cpu_addr),
  .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .irq_req(irq_req));

// file: verification/tbx_cpu_model.sv
// cpu core model driving byte accesses on the timer port
`timescale 1ns/10ps
module tbx_cpu_model
(
  // clock
  input wire logic clk,
  // byte port
  output logic [3:0] cpu_addr,
  output logic cpu_wr,
  output logic cpu_rd,
  output logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata
);
  initial
  begin
    cpu_addr = 4'hF;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_wdata = 8'h00;
  end
  // one strobe cycle; idle lines then show the inverse so stale data never looks valid
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1;
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = w;
    cpu_rd = !w;
    @(posedge clk);
    #1;
    q = cpu_rdata;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_addr = ~a;
    cpu_wdata = ~d;
  endtask : acc
  // word transfers issue their two byte accesses one idle cycle apart, with no other access in between
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    logic [7:0] q;
    acc(1'b1, a | 4'h1, d[15:8], q);
    acc(1'b1, a, d[7:0], q);
  endtask : wr16
  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    acc(1'b0, a, 8'h00, d[7:0]);
    acc(1'b0, a | 4'h1, 8'h00, d[15:8]);
  endtask : rd16
endmodule : tbx_cpu_model

// file: verification/timer16_byte_access_test.sv
// self-checking bench for the 16-bit timer byte port
`timescale 1ns/10ps
module timer16_byte_access_test;
  import tbx_pkg::*;
  logic clk, arst_n, presc_tick, external_count_pin, capture_pin, acmp_out, cap_src_acmp;
  logic cpu_wr, cpu_rd, compare_a_output, compare_b_output;
  logic [3:0] cpu_addr;
  logic [7:0] cpu_wdata, cpu_rdata, irq_req, q;
  logic [15:0] w;
  int err_count, n_tests;
  tbx_timer16 u_tbx_timer16 (.clk(clk), .arst_n(arst_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .presc_tick(presc_tick), .external_count_pin(external_count_pin),
    .capture_pin(capture_pin), .acmp_out(acmp_out), .cap_src_acmp(cap_src_acmp),
    .compare_a_output(compare_a_output), .compare_b_output(compare_b_output), .irq_req(irq_req));
  tbx_cpu_model u_tbx_cpu_model (.clk(clk), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));
  // clock, and a free prescaler tick that a stopped timer must ignore
  always #2.5 clk = ~clk;
  always @(posedge clk) presc_tick <= #1 ~presc_tick;
  // compare helpers
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rb(input logic [3:0] a, input logic [7:0] e);
    u_tbx_cpu_model.acc(1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask : rb
  task automatic wb(input logic [3:0] a, input logic [7:0] d);
    u_tbx_cpu_model.acc(1'b1, a, d, q);
  endtask : wb
  task automatic r16(input logic [3:0] a, input logic [15:0] e);
    u_tbx_cpu_model.rd16(a, w);
    chk(w, e);
  endtask : r16
  // n rising edges, each level held three cycles to respect the pin synchroniser
  task automatic ext_edges(input int n);
    repeat (2 * n)
    begin
      repeat (3) @(posedge clk);
      #1 external_count_pin = ~external_count_pin;
    end
    repeat (6) @(posedge clk);
  endtask : ext_edges
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  // watchdog well beyond the expected few hundred cycles
  initial
  begin
    #20000;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    presc_tick = 1'b0;
    external_count_pin = 1'b0;
    capture_pin = 1'b0;
    acmp_out = 1'b0;
    cap_src_acmp = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (2) @(posedge clk);
    // reset values and an unmapped place
    rb(ADDR_CTRL_A, CTRL_RST);
    rb(ADDR_CTRL_B, CTRL_RST);
    rb(ADDR_MASK, 8'h00);
    rb(4'hC, 8'h00);
    // word write then word read with the clock stopped
    u_tbx_cpu_model.wr16(ADDR_CNT_LO, 16'h01FF);
    repeat (8) @(posedge clk);
    r16(ADDR_CNT_LO, 16'h01FF);
    // one holder for every word register; high writes touch nothing else
    wb(ADDR_CMPA_HI, 8'h12);
    wb(ADDR_CNT_LO, 8'h34);
    wb(ADDR_CNT_HI, 8'hAB);
    r16(ADDR_CNT_LO, 16'h1234);
    r16(ADDR_CMPA_LO, REG16_RST);
    // compare high reads are live, count high reads give the holder
    u_tbx_cpu_model.wr16(ADDR_CMPA_LO, 16'h5678);
    u_tbx_cpu_model.wr16(ADDR_CMPB_LO, 16'h9ABC);
    wb(ADDR_CNT_HI, 8'h77);
    rb(ADDR_CMPB_HI, 8'h9A);
    rb(ADDR_CMPA_HI, 8'h56);
    rb(ADDR_CNT_HI, 8'h77);
    // plain control access; force strobes read back as zero
    wb(ADDR_CTRL_A, 8'h0D);
    rb(ADDR_CTRL_A, 8'h01);
    chk({14'h0000, compare_a_output, compare_b_output}, 16'h0003);
    wb(ADDR_CTRL_A, CTRL_RST);
    // capture writes are refused until capture sets the top
    u_tbx_cpu_model.wr16(ADDR_CAP_LO, 16'h1111);
    r16(ADDR_CAP_LO, REG16_RST);
    wb(ADDR_CTRL_B, 8'hD8);
    rb(ADDR_CTRL_B, 8'hD8);
    u_tbx_cpu_model.wr16(ADDR_CAP_LO, 16'h2222);
    r16(ADDR_CAP_LO, 16'h2222);
    wb(ADDR_CTRL_B, CTRL_RST);
    // external edges pass compare A; mask gates the request
    u_tbx_cpu_model.wr16(ADDR_CMPA_LO, 16'h0003);
    u_tbx_cpu_model.wr16(ADDR_CNT_LO, CNT_BOTTOM);
    wb(ADDR_FLAG, 8'hFF);
    wb(ADDR_MASK, 8'h02);
    wb(ADDR_CTRL_B, {5'h00, CS_EXT_RISE});
    ext_edges(5);
    wb(ADDR_CTRL_B, CTRL_RST);
    r16(ADDR_CNT_LO, 16'h0005);
    rb(ADDR_FLAG, 8'h02);
    chk({8'h00, irq_req}, 16'h0002);
    chk({14'h0000, compare_a_output, compare_b_output}, 16'h0001);
    wb(ADDR_MASK, 8'h00);
    repeat (3) @(posedge clk);
    chk({8'h00, irq_req}, 16'h0000);
    wb(ADDR_FLAG, 8'h02);
    rb(ADDR_FLAG, 8'h00);
    // wrap through max to bottom
    u_tbx_cpu_model.wr16(ADDR_CNT_LO, 16'hFFFE);
    wb(ADDR_CTRL_B, {5'h00, CS_EXT_RISE});
    ext_edges(2);
    wb(ADDR_CTRL_B, CTRL_RST);
    r16(ADDR_CNT_LO, CNT_BOTTOM);
    rb(ADDR_FLAG, 8'h01);
    wb(ADDR_FLAG, 8'hFF);
    // prescaler tick alternates, so twenty enabled edges give ten counts
    u_tbx_cpu_model.wr16(ADDR_CNT_LO, CNT_BOTTOM);
    wb(ADDR_CTRL_B, 8'h01);
    repeat (18) @(posedge clk);
    wb(ADDR_CTRL_B, CTRL_RST);
    r16(ADDR_CNT_LO, 16'h000A);
    rb(ADDR_FLAG, 8'h02);
    chk({14'h0000, compare_a_output, compare_b_output}, 16'h0003);
    wb(ADDR_FLAG, 8'hFF);
    // pin capture of a stopped count
    wb(ADDR_CTRL_B, 8'h40);
    u_tbx_cpu_model.wr16(ADDR_CNT_LO, 16'h0042);
    capture_pin = 1'b1;
    repeat (6) @(posedge clk);
    rb(ADDR_FLAG, 8'h20);
    r16(ADDR_CAP_LO, 16'h0042);
    wb(ADDR_FLAG, 8'hFF);
    // filtered comparator path: a short spike is dropped, a steady level captures
    wb(ADDR_CTRL_B, 8'hC0);
    capture_pin = 1'b0;
    cap_src_acmp = 1'b1;
    u_tbx_cpu_model.wr16(ADDR_CNT_LO, 16'h0043);
    acmp_out = 1'b1;
    repeat (2) @(posedge clk);
    #1 acmp_out = 1'b0;
    repeat (8) @(posedge clk);
    rb(ADDR_FLAG, 8'h00);
    acmp_out = 1'b1;
    repeat (10) @(posedge clk);
    rb(ADDR_FLAG, 8'h20);
    r16(ADDR_CAP_LO, 16'h0043);
    results();
  end
endmodule : timer16_byte_access_test
